// ===== rtl/twe_eeprom_target.sv
`timescale 1ns/10ps
`default_nettype none
module twe_eeprom_target
  import twe_pkg::*;
#(
  parameter int PROG_CYCLES = INTERNAL_PROGRAM_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic write_protect,
  output logic write_busy
);
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  // ****************************************
  // Pin front end
  // ****************************************
  twe_bus_if ev ();

  twe_pin_sync u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .scl_pin(scl_pin),
    .sda_pin(sda_in),
    .ev(ev)
  );

  logic wp_meta;
  logic wp_sync;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= write_protect;
      wp_sync <= wp_meta;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] mem [MEM_DEPTH];
  logic [DATA_W-1:0] lat [PAGE_BYTES];

  // ****************************************
  // Protocol state
  // ****************************************
  twe_state_e state;
  twe_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] next_sh;
  logic [DATA_W-1:0] tx;
  logic [DATA_W-1:0] next_tx;
  logic drive_low;
  logic next_drive_low;
  logic rd;
  logic next_rd;
  logic [BLK_W-1:0] blk;
  logic [BLK_W-1:0] next_blk;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] next_addr;
  logic [PAGE_W-1:0] wr_page;
  logic [PAGE_W-1:0] next_page;
  logic [OFF_W-1:0] wr_off;
  logic [OFF_W-1:0] next_off;
  logic [PAGE_BYTES-1:0] lat_v;
  logic [PAGE_BYTES-1:0] next_lat_v;
  logic lat_we;
  logic pop;
  logic flush;
  logic prog_go;
  logic prog_done;

  // Program timer state
  logic busy;
  logic next_busy;
  logic [PCW-1:0] pcnt;
  logic [PCW-1:0] next_pcnt;
  logic mem_we;

  // Prefetch state
  logic [ADDR_W-1:0] pf_addr;
  logic [ADDR_W-1:0] next_pf_addr;
  logic pf_valid;
  logic pf_ready;
  logic rd_valid;
  logic [DATA_W-1:0] rd_data;

  // ****************************************
  // Read prefetch buffer
  // ****************************************
  assign pf_valid = !busy;

  twe_skid_fifo u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .flush(flush),
    .in_valid(pf_valid),
    .in_ready(pf_ready),
    .in_data(mem[pf_addr]),
    .out_valid(rd_valid),
    .out_ready(pop),
    .out_data(rd_data)
  );

  always_comb begin
    next_pf_addr = pf_addr;
    if (flush) begin
      next_pf_addr = next_addr;
    end else if (pf_valid && pf_ready) begin
      next_pf_addr = ADDR_W'(pf_addr + 11'h001);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pf_addr <= '0;
    end else begin
      pf_addr <= next_pf_addr;
    end
  end

  // ****************************************
  // Byte engine
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_tx = tx;
    next_drive_low = drive_low;
    next_rd = rd;
    next_blk = blk;
    next_addr = cur_addr;
    next_page = wr_page;
    next_off = wr_off;
    next_lat_v = lat_v;
    lat_we = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    prog_go = 1'b0;
    if (prog_done) begin
      next_lat_v = '0;
    end
    if (ev.start) begin
      next_state = ST_DEV;
      next_cnt = 4'h0;
      next_drive_low = 1'b0;
      flush = 1'b1;
    end else if (ev.stop) begin
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
      if (!busy && (lat_v != '0)) begin
        if (wp_sync) begin
          next_lat_v = '0;
        end else begin
          prog_go = 1'b1;
        end
      end
    end else begin
      case (state)
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (ev.scl_rise) begin
            next_sh = {sh[6:0], ev.sda_bit};
            next_cnt = 4'(cnt + 4'h1);
          end else if (ev.scl_fall && (cnt == BITS_PER_BYTE)) begin
            next_cnt = 4'h0;
            next_drive_low = 1'b1;
            if (state == ST_DEV) begin
              if ((sh[7:4] == DEV_TYPE) && !busy) begin
                next_blk = sh[3:1];
                next_rd = sh[0];
                next_state = ST_DEV_ACK;
                if (!sh[0]) begin
                  next_lat_v = '0;
                end
              end else begin
                next_drive_low = 1'b0;
                next_state = ST_IDLE;
              end
            end else if (state == ST_WADDR) begin
              next_addr = {blk, sh};
              next_page = {blk, sh[7:4]};
              next_off = sh[3:0];
              flush = 1'b1;
              next_state = ST_WADDR_ACK;
            end else begin
              lat_we = 1'b1;
              next_lat_v[wr_off] = 1'b1;
              next_off = OFF_W'(wr_off + 4'h1);
              next_addr = {wr_page, OFF_W'(wr_off + 4'h1)};
              flush = 1'b1;
              next_state = ST_WDATA_ACK;
            end
          end
        end
        ST_DEV_ACK, ST_WADDR_ACK, ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            next_drive_low = 1'b0;
            next_cnt = 4'h0;
            if (state == ST_DEV_ACK && rd) begin
              pop = rd_valid;
              next_tx = rd_valid ? rd_data : IDLE_BYTE;
              next_drive_low = ~next_tx[7];
              next_addr = ADDR_W'(cur_addr + 11'h001);
              next_state = ST_RDATA;
            end else begin
              next_state = ST_WDATA;
              if (state == ST_DEV_ACK) begin
                next_state = ST_WADDR;
              end
            end
          end
        end
        ST_RDATA: begin
          if (ev.scl_rise) begin
            next_cnt = 4'(cnt + 4'h1);
          end else if (ev.scl_fall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_drive_low = 1'b0;
              next_cnt = 4'h0;
              next_state = ST_RACK;
            end else begin
              next_tx = {tx[6:0], 1'b1};
              next_drive_low = ~tx[6];
            end
          end
        end
        ST_RACK: begin
          if (ev.scl_rise) begin
            next_sh = {sh[7:1], ev.sda_bit};
            next_cnt = 4'h1;
          end else if (ev.scl_fall && (cnt != 4'h0)) begin
            next_cnt = 4'h0;
            if (!sh[0]) begin
              pop = rd_valid;
              next_tx = rd_valid ? rd_data : IDLE_BYTE;
              next_drive_low = ~next_tx[7];
              next_addr = ADDR_W'(cur_addr + 11'h001);
              next_state = ST_RDATA;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      sh <= 8'hFF;
      tx <= 8'hFF;
      drive_low <= 1'b0;
      rd <= 1'b0;
      blk <= 3'h0;
      cur_addr <= '0;
      wr_page <= '0;
      wr_off <= '0;
      lat_v <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      tx <= next_tx;
      drive_low <= next_drive_low;
      rd <= next_rd;
      blk <= next_blk;
      cur_addr <= next_addr;
      wr_page <= next_page;
      wr_off <= next_off;
      lat_v <= next_lat_v;
    end
  end

  // ****************************************
  // Self-timed programming
  // ****************************************
  assign prog_done = busy && (pcnt == PCW'(PROG_CYCLES - 1));
  assign mem_we = busy && (pcnt < PCW'(PAGE_BYTES)) && lat_v[pcnt[OFF_W-1:0]];

  always_comb begin
    next_busy = busy;
    next_pcnt = pcnt;
    if (prog_go) begin
      next_busy = 1'b1;
      next_pcnt = '0;
    end else if (prog_done) begin
      next_busy = 1'b0;
      next_pcnt = '0;
    end else if (busy) begin
      next_pcnt = PCW'(pcnt + 1'b1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy <= 1'b0;
      pcnt <= '0;
    end else begin
      busy <= next_busy;
      pcnt <= next_pcnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (lat_we) begin
      lat[wr_off] <= sh;
    end
    if (mem_we) begin
      mem[{wr_page, pcnt[OFF_W-1:0]}] <= lat[pcnt[OFF_W-1:0]];
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  assign sda_out = 1'b0;
  assign sda_oe = drive_low;
  assign write_busy = busy;
endmodule : twe_eeprom_target
`default_nettype wire

// ===== rtl/twe_pkg.sv
// Functional notes
// - Bits are sampled on each rising serial clock edge, and outgoing bits change on each falling edge.
// - The data pin is only ever pulled low or released, never driven high.
// - The chip-select address pins play no part in address matching, so only one such device can sit on a bus.
// - With write protect low, reads and writes work normally over the whole array.
// - With write protect high, no write reaches the array and the stored contents stay as they are.
// - Storage is 128 pages of 16 bytes, and any byte is chosen by an 11-bit word address.
// - A page write takes up to 16 bytes within one page, and a shorter partial page is committed as well.
// - After a write sequence ends, the device programs the array on its own timer within 5 ms.
// - Data falling while the clock is high is a start, data rising while the clock is high is a stop.
// - Bytes are eight bits; the receiver acknowledges by holding data low on the ninth clock.
// - The selection byte carries the 1010 pattern, three upper address bits and a read bit.
// - The selection byte is not acknowledged while programming runs, and is once it has finished.
package twe_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 2048;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_W = 7;
  localparam int OFF_W = 4;
  localparam int BLK_W = 3;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int INTERNAL_PROGRAM_TIME_US = 5000;
  localparam int CLK_FREQ_MHZ = 20;
  localparam int INTERNAL_PROGRAM_CYCLES = INTERNAL_PROGRAM_TIME_US * CLK_FREQ_MHZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_DEV = 4'h1,
    ST_DEV_ACK = 4'h2,
    ST_WADDR = 4'h3,
    ST_WADDR_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } twe_state_e;
endpackage : twe_pkg

// ===== rtl/twe_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
interface twe_bus_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_bit;
  modport prod (output scl_rise, output scl_fall, output start, output stop, output sda_bit);
  modport cons (input scl_rise, input scl_fall, input start, input stop, input sda_bit);
endinterface : twe_bus_if
`default_nettype wire

// ===== rtl/twe_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module twe_pin_sync
  import twe_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  twe_bus_if.prod ev
);
  // ****************************************
  // Synchroniser and edge history
  // ****************************************
  logic [2:0] scl_pipe;
  logic [2:0] sda_pipe;
  logic [2:0] next_scl_pipe;
  logic [2:0] next_sda_pipe;

  always_comb begin
    next_scl_pipe = {scl_pipe[1:0], scl_pin};
    next_sda_pipe = {sda_pipe[1:0], sda_pin};
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_pipe <= 3'h7;
      sda_pipe <= 3'h7;
    end else begin
      scl_pipe <= next_scl_pipe;
      sda_pipe <= next_sda_pipe;
    end
  end

  // ****************************************
  // Events
  // ****************************************
  assign ev.scl_rise = scl_pipe[1] & ~scl_pipe[2];
  assign ev.scl_fall = ~scl_pipe[1] & scl_pipe[2];
  assign ev.start = scl_pipe[1] & scl_pipe[2] & sda_pipe[2] & ~sda_pipe[1];
  assign ev.stop = scl_pipe[1] & scl_pipe[2] & ~sda_pipe[2] & sda_pipe[1];
  assign ev.sda_bit = sda_pipe[1];
endmodule : twe_pin_sync
`default_nettype wire

// ===== rtl/twe_skid_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module twe_skid_fifo
  import twe_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);
  // ****************************************
  // Two-entry storage
  // ****************************************
  logic [DATA_W-1:0] slot [2];
  logic wptr;
  logic rptr;
  logic [1:0] fill;
  logic next_wptr;
  logic next_rptr;
  logic [1:0] next_fill;
  logic push;
  logic pop;

  assign in_ready = (fill != 2'h2) && !flush;
  assign out_valid = (fill != 2'h0);
  assign out_data = slot[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_fill = fill;
    if (flush) begin
      next_wptr = 1'b0;
      next_rptr = 1'b0;
      next_fill = 2'h0;
    end else begin
      if (push) begin
        next_wptr = ~wptr;
      end
      if (pop) begin
        next_rptr = ~rptr;
      end
      next_fill = 2'(fill + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      fill <= 2'h0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      fill <= next_fill;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      slot[wptr] <= in_data;
    end
  end
endmodule : twe_skid_fifo
`default_nettype wire

// ===== tb/twe_target_props.sv
`timescale 1ns/10ps
`default_nettype none
module twe_target_props #(
  parameter int PROG_CYCLES = 100000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic write_busy
);
  // ***
  // Busy length counter
  // ***
  logic [31:0] busy_cnt;
  logic [31:0] next_busy_cnt;
  always_comb begin
    next_busy_cnt = write_busy ? busy_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge core_clk) begin
    busy_cnt <= srst ? 32'h0 : next_busy_cnt;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_OD_LOW: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_SCL_HIGH: assert property (scl_pin |-> $stable(sda_oe))
    else $error("data output moved while clock high");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("pull low too short");
  AST_BUSY_QUIET: assert property (write_busy |-> !sda_oe)
    else $error("bus answered while programming");
  AST_STOP: assert property ($rose(write_busy) |-> scl_pin && sda_in && !$past(sda_in, 6))
    else $error("programming began without stop");
  AST_WP: assert property ($rose(write_busy) |-> !write_protect && !$past(write_protect, 4))
    else $error("programming while protected");
  AST_BUSY_LEN: assert property (busy_cnt <= 32'(PROG_CYCLES))
    else $error("programming too long");
  AST_BUSY_FULL: assert property ($fell(write_busy) |-> busy_cnt == 32'(PROG_CYCLES))
    else $error("programming length wrong");
endmodule : twe_target_props
bind twe_eeprom_target twe_target_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .core_clk(core_clk), .srst(srst), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_protect(write_protect), .write_busy(write_busy));
`default_nettype wire

// ===== tb/twe_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module twe_master_model #(
  parameter int H = 10
) (
  input wire logic core_clk,
  input wire logic sda,
  output var logic scl,
  output var logic m_oe
);
  // ***
  // Bus master, clock period of 23 core cycles (3 + H low, H high)
  // ***
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic hc();
    repeat (H) @(negedge core_clk);
  endtask : hc
  task automatic bx(input logic b, output logic r);
    repeat (3) @(negedge core_clk);
    m_oe = !b;
    hc();
    scl = 1'b1;
    hc();
    r = sda;
    scl = 1'b0;
  endtask : bx
  task automatic xb(input logic [7:0] d, input logic b9, output logic [7:0] q, output logic r9);
    int i;
    logic t;
    for (i = 7; i >= 0; i--) begin
      bx(d[i], t);
      q = {q[6:0], t};
    end
    bx(b9, r9);
  endtask : xb
  task automatic start();
    repeat (3) @(negedge core_clk);
    m_oe = 1'b0;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b1;
    hc();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    repeat (3) @(negedge core_clk);
    m_oe = 1'b1;
    hc();
    scl = 1'b1;
    hc();
    m_oe = 1'b0;
    hc();
  endtask : stop
endmodule : twe_master_model
`default_nettype wire

// ===== tb/tb_twe_eeprom_target.sv
`timescale 1ns/10ps
`default_nettype none
module tb_twe_eeprom_target import twe_pkg::*;;
  `define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic write_protect = 1'b0;
  logic scl, m_oe, sda_oe, sda_out, write_busy, sda, a;
  logic [7:0] q;
  logic [7:0] mem [0:2047];
  int bad_count = 0;
  int checks = 0;
  logic [18:0] rows [6] = '{{11'h000, 8'h5A}, {11'h7FF, 8'hC3}, {11'h123, 8'h00},
    {11'h4A7, 8'hFF}, {11'h3F0, 8'h81}, {11'h6AC, 8'h3C}};
  always #25 core_clk = ~core_clk;
  assign sda = !(sda_oe || m_oe);
  twe_eeprom_target #(.PROG_CYCLES(400)) dut (.core_clk(core_clk), .srst(srst),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .write_busy(write_busy));
  twe_master_model mm (.core_clk(core_clk), .sda(sda), .scl(scl), .m_oe(m_oe));
  // ***
  // Transfers
  // ***
  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [10:0] ad, input int n, input logic [7:0] d0);
    int i;
    mm.start();
    mm.xb({DEV_TYPE, ad[10:8], 1'b0}, 1'b1, q, a);
    `CHK("sel_ack", 1'b0, a)
    mm.xb(ad[7:0], 1'b1, q, a);
    `CHK("addr_ack", 1'b0, a)
    for (i = 0; i < n; i++) begin
      mm.xb(d0 + 8'(i), 1'b1, q, a);
      `CHK("data_ack", 1'b0, a)
      if (!write_protect) mem[{ad[10:4], ad[3:0] + 4'(i)}] = d0 + 8'(i);
    end
    mm.stop();
  endtask : wr
  task automatic poll(output int np);
    int k;
    np = 0;
    for (k = 0; k < 20; k++) begin
      mm.start();
      mm.xb({DEV_TYPE, 4'h0}, 1'b1, q, a);
      if (a === 1'b0) break;
      np++;
      mm.stop();
    end
    if (k == 20) begin
      bad_count++;
      summarize();
    end
  endtask : poll
  task automatic rd(input logic [10:0] ad, input int n);
    int i;
    mm.start();
    mm.xb({DEV_TYPE, ad[10:8], 1'b0}, 1'b1, q, a);
    mm.xb(ad[7:0], 1'b1, q, a);
    mm.start();
    mm.xb({DEV_TYPE, 4'h1}, 1'b1, q, a);
    `CHK("rsel_ack", 1'b0, a)
    for (i = 0; i < n; i++) begin
      mm.xb(IDLE_BYTE, i == n - 1, q, a);
      `CHK("rdata", mem[ad + 11'(i)], q)
    end
    mm.stop();
  endtask : rd
  initial begin
    int r;
    int np;
    repeat (20) @(negedge core_clk);
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("rst_oe", 1'b0, sda_oe)
    `CHK("rst_busy", 1'b0, write_busy)
    for (r = 0; r < 6; r++) begin
      wr(rows[r][18:8], 1, rows[r][7:0]);
      `CHK("busy", 1'b1, write_busy)
      poll(np);
      `CHK("poll_nack", 1'b1, np > 0)
      rd(rows[r][18:8], 1);
    end
    wr(11'h2A5, 17, 8'h40);
    poll(np);
    mm.start();
    mm.xb({DEV_TYPE, 4'hF}, 1'b1, q, a);
    mm.xb(IDLE_BYTE, 1'b1, q, a);
    `CHK("cur_rd", mem[11'h2A6], q)
    mm.stop();
    rd(11'h2A0, 16);
    rd(11'h7FF, 2);
    write_protect = 1'b1;
    repeat (10) @(negedge core_clk);
    wr(11'h123, 1, 8'hEE);
    repeat (20) @(negedge core_clk);
    `CHK("wp_busy", 1'b0, write_busy)
    write_protect = 1'b0;
    rd(11'h123, 1);
    mm.start();
    mm.xb(8'h50, 1'b1, q, a);
    `CHK("bad_sel", 1'b1, a)
    mm.stop();
    wr(rows[4][18:8], 1, rows[4][7:0]);
    srst = 1'b1;
    repeat (20) @(negedge core_clk);
    `CHK("mid_busy", 1'b0, write_busy)
    `CHK("mid_oe", 1'b0, sda_oe)
    srst = 1'b0;
    repeat (4) @(negedge core_clk);
    poll(np);
    `CHK("mid_poll", 1'b1, np == 0)
    summarize();
  end
endmodule : tb_twe_eeprom_target
`default_nettype wire
